// *** ebs_sequencer.sv ***
`timescale 1ns/100ps
// Overview of operation
// [RULE_01] Multiplexed four-state cycle runs T1, T2, T3, T4 plus stall states.
// [RULE_02] Multiplexed read T1 puts address on data pins, chip select asserted.
// [RULE_03] Address latch pulse high at start of T1, low from mid T1.
// [RULE_04] Read T2 frees data pins, asserts read strobe and memory or io request.
// [RULE_05] T3 holds bus; ready low before T3 ends adds stalls until high.
// [RULE_06] Start of read T4 captures data, drops read strobe, cycle then ends.
// [RULE_07] Write T2 replaces address on data pins by write data, write strobe low.
// [RULE_08] Write T4 drops write strobe, holds address and data until T4 ends.
// [RULE_09] Eight-state cycle steps S0 to S7 in order plus stall states.
// [RULE_10] Eight-state read drives direction select high in S0.
// [RULE_11] Full 24-bit address valid on entering S1.
// [RULE_12] Read S2 starts with address strobe and data strobe asserted.
// [RULE_13] Read S3 and S5 change no bus signal.
// [RULE_14] No transfer acknowledge by end of S4 inserts stalls until asserted.
// [RULE_15] Each eight-state stall lasts one whole bus state period.
// [RULE_16] Four-state bus state length programmable from 2 to 15 clocks.
// [RULE_17] Low address byte also stays on address pins in multiplexed mode.
// [RULE_18] Peripheral drives data in S6; entering S7 captures data, drops strobes.
// [RULE_19] Bus mode change costs one extra clock; same mode costs none.
// [RULE_20] Strobes, requests and transfer acknowledge are active low.
module ebs_sequencer (
	input  wire logic                        sys_clk,
	input  wire logic                        rst_n,
	input  wire logic                        req_valid,
	output logic                             req_ready,
	input  wire ebs_pkg::ebs_req_t           req,
	input  wire logic [ebs_pkg::LEN_W-1:0]   state_len,
	output logic                             rsp_valid,
	output logic      [ebs_pkg::DATA_W-1:0]  rsp_rdata,
	output ebs_pkg::ebs_bus_t                bus,
	input  wire logic [ebs_pkg::DATA_W-1:0]  data_in,
	input  wire logic                        ready_in,
	input  wire logic                        transfer_ack_n
);

	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [ebs_pkg::LEN_W-1:0] clamp_len(
		input logic [ebs_pkg::LEN_W-1:0] l
	);
		if (l < ebs_pkg::LEN_MIN) begin
			return ebs_pkg::LEN_MIN;
		end
		return l;
	endfunction

	function automatic ebs_pkg::ebs_state_t first_state(input ebs_pkg::ebs_mode_t m);
		if (m == ebs_pkg::EBS_MODE_STROBE8) begin
			return ebs_pkg::ST_S0;
		end
		return ebs_pkg::ST_T1;
	endfunction

	function automatic ebs_pkg::ebs_bus_t bus_of(
		input ebs_pkg::ebs_state_t      st,
		input logic [ebs_pkg::LEN_W-1:0] cnt,
		input logic [ebs_pkg::LEN_W-1:0] len,
		input ebs_pkg::ebs_req_t        r
	);
		ebs_pkg::ebs_bus_t b;
		logic mux_act;
		logic s_act;
		b = ebs_pkg::BUS_IDLE;
		mux_act = st inside {ebs_pkg::ST_T2, ebs_pkg::ST_T3, ebs_pkg::ST_TSTALL, ebs_pkg::ST_T4};
		s_act = st inside {ebs_pkg::ST_S0, ebs_pkg::ST_S1, ebs_pkg::ST_S2, ebs_pkg::ST_S3,
			ebs_pkg::ST_S4, ebs_pkg::ST_SSTALL, ebs_pkg::ST_S5, ebs_pkg::ST_S6, ebs_pkg::ST_S7};
		b.addr_out = r.addr; // [RULE_11] [RULE_17]
		if (st == ebs_pkg::ST_T1) begin
			b.chip_select_n = 1'b0; // [RULE_02]
			b.data_oe       = 1'b1; // [RULE_02]
			b.data_out      = r.addr[ebs_pkg::DATA_W-1:0];
			b.ale           = (cnt < (len >> 1)); // [RULE_03]
		end else if (mux_act) begin
			b.chip_select_n    = 1'b0;
			b.memory_request_n = r.io; // [RULE_04] [RULE_20]
			b.io_request_n     = ~r.io;
			if (r.write) begin
				b.data_oe        = 1'b1; // [RULE_07] [RULE_08]
				b.data_out       = r.wdata;
				b.write_strobe_n = (st == ebs_pkg::ST_T4); // [RULE_07] [RULE_08]
			end else begin
				b.read_strobe_n  = (st == ebs_pkg::ST_T4); // [RULE_04] [RULE_06]
			end
		end else if (s_act) begin
			b.chip_select_n = 1'b0;
			if (r.write) begin
				b.rw_dir = st inside {ebs_pkg::ST_S0, ebs_pkg::ST_S1};
				b.address_strobe_n = !(st inside {ebs_pkg::ST_S2, ebs_pkg::ST_S3,
					ebs_pkg::ST_S4, ebs_pkg::ST_SSTALL, ebs_pkg::ST_S5, ebs_pkg::ST_S6});
				b.data_strobe_n = !(st inside {ebs_pkg::ST_S4, ebs_pkg::ST_SSTALL,
					ebs_pkg::ST_S5, ebs_pkg::ST_S6});
				b.data_oe = !(st inside {ebs_pkg::ST_S0, ebs_pkg::ST_S1, ebs_pkg::ST_S2});
				b.data_out = r.wdata;
			end else begin
				b.rw_dir = 1'b1; // [RULE_10]
				b.address_strobe_n = !(st inside {ebs_pkg::ST_S2, ebs_pkg::ST_S3,
					ebs_pkg::ST_S4, ebs_pkg::ST_SSTALL, ebs_pkg::ST_S5, ebs_pkg::ST_S6}); // [RULE_12]
				b.data_strobe_n = b.address_strobe_n; // [RULE_12] [RULE_18] [RULE_20]
			end
		end
		return b;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic rdy_s1_q, rdy_s2_q, rdy_s3_q, rdy_f_q, rdy_f_d;
	logic ack_s1_q, ack_s2_q, ack_s3_q, ack_f_q, ack_f_d;

	always_comb begin
		rdy_f_d = (rdy_s2_q == rdy_s3_q) ? rdy_s3_q : rdy_f_q;
		ack_f_d = (ack_s2_q == ack_s3_q) ? ack_s3_q : ack_f_q;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdy_s1_q <= ebs_pkg::READY_RST;
			rdy_s2_q <= ebs_pkg::READY_RST;
			rdy_s3_q <= ebs_pkg::READY_RST;
			rdy_f_q  <= ebs_pkg::READY_RST;
			ack_s1_q <= ebs_pkg::ACK_N_RST;
			ack_s2_q <= ebs_pkg::ACK_N_RST;
			ack_s3_q <= ebs_pkg::ACK_N_RST;
			ack_f_q  <= ebs_pkg::ACK_N_RST;
		end else begin
			rdy_s1_q <= ready_in;
			rdy_s2_q <= rdy_s1_q;
			rdy_s3_q <= rdy_s2_q;
			rdy_f_q  <= rdy_f_d;
			ack_s1_q <= transfer_ack_n;
			ack_s2_q <= ack_s1_q;
			ack_s3_q <= ack_s2_q;
			ack_f_q  <= ack_f_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State timer
	ebs_pkg::ebs_state_t st_q, st_d;
	logic [ebs_pkg::LEN_W-1:0] len_q, len_d;
	logic [ebs_pkg::LEN_W-1:0] tm_cnt, tm_cnt_d;
	logic tm_last;
	logic tm_clear;

	assign tm_clear = (st_q == ebs_pkg::ST_IDLE) || (st_q == ebs_pkg::ST_SWITCH);

	ebs_state_timer u_timer (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.clear   (tm_clear),
		.len     (len_q),
		.cnt_q   (tm_cnt),
		.cnt_d   (tm_cnt_d),
		.last    (tm_last)
	);

	////////////////////////////////////////////////////////////////////////
	// Cycle sequencer
	ebs_pkg::ebs_req_t   cmd_q, cmd_d;
	ebs_pkg::ebs_mode_t  mode_q, mode_d;
	ebs_pkg::ebs_bus_t   bus_q, bus_d;
	logic started_q, started_d;
	logic rsp_valid_q, rsp_valid_d;
	logic [ebs_pkg::DATA_W-1:0] cap_q, cap_d;

	assign req_ready = (st_q == ebs_pkg::ST_IDLE);
	assign rsp_valid = rsp_valid_q;
	assign rsp_rdata = cap_q;
	assign bus       = bus_q;

	always_comb begin
		st_d        = st_q;
		len_d       = len_q;
		cmd_d       = cmd_q;
		mode_d      = mode_q;
		started_d   = started_q;
		cap_d       = cap_q;
		rsp_valid_d = 1'b0;
		case (st_q)
			ebs_pkg::ST_IDLE: begin
				if (req_valid) begin
					cmd_d     = req;
					len_d     = clamp_len(state_len); // [RULE_16]
					mode_d    = req.mode;
					started_d = 1'b1;
					if (started_q && (req.mode != mode_q)) begin
						st_d = ebs_pkg::ST_SWITCH; // [RULE_19]
					end else begin
						st_d = first_state(req.mode);
					end
				end
			end
			ebs_pkg::ST_SWITCH: begin
				st_d = first_state(cmd_q.mode); // [RULE_19]
			end
			ebs_pkg::ST_T1: begin
				if (tm_last) begin
					st_d = ebs_pkg::ST_T2; // [RULE_01]
				end
			end
			ebs_pkg::ST_T2: begin
				if (tm_last) begin
					st_d = ebs_pkg::ST_T3;
				end
			end
			ebs_pkg::ST_T3, ebs_pkg::ST_TSTALL: begin
				if (tm_last) begin
					st_d = rdy_f_q ? ebs_pkg::ST_T4 : ebs_pkg::ST_TSTALL; // [RULE_05]
				end
			end
			ebs_pkg::ST_T4: begin
				if (tm_last) begin
					st_d        = ebs_pkg::ST_IDLE; // [RULE_06] [RULE_08]
					rsp_valid_d = 1'b1;
				end
			end
			ebs_pkg::ST_S0: begin
				if (tm_last) begin
					st_d = ebs_pkg::ST_S1; // [RULE_09]
				end
			end
			ebs_pkg::ST_S1: begin
				if (tm_last) begin
					st_d = ebs_pkg::ST_S2;
				end
			end
			ebs_pkg::ST_S2: begin
				if (tm_last) begin
					st_d = ebs_pkg::ST_S3;
				end
			end
			ebs_pkg::ST_S3: begin
				if (tm_last) begin
					st_d = ebs_pkg::ST_S4;
				end
			end
			ebs_pkg::ST_S4, ebs_pkg::ST_SSTALL: begin
				if (tm_last) begin
					st_d = ack_f_q ? ebs_pkg::ST_SSTALL : ebs_pkg::ST_S5; // [RULE_14] [RULE_15]
				end
			end
			ebs_pkg::ST_S5: begin
				if (tm_last) begin
					st_d = ebs_pkg::ST_S6;
				end
			end
			ebs_pkg::ST_S6: begin
				if (tm_last) begin
					st_d = ebs_pkg::ST_S7;
				end
			end
			ebs_pkg::ST_S7: begin
				if (tm_last) begin
					st_d        = ebs_pkg::ST_IDLE;
					rsp_valid_d = 1'b1;
				end
			end
			default: begin
				st_d = ebs_pkg::ST_IDLE;
			end
		endcase
		if (!cmd_d.write && (st_q != st_d) &&
			((st_d == ebs_pkg::ST_T4) || (st_d == ebs_pkg::ST_S7))) begin
			cap_d = data_in; // [RULE_06] [RULE_18]
		end
		bus_d = bus_of(st_d, tm_cnt_d, len_d, cmd_d);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q        <= ebs_pkg::ST_IDLE;
			len_q       <= ebs_pkg::LEN_MIN;
			cmd_q       <= '0;
			mode_q      <= ebs_pkg::EBS_MODE_MUX4;
			started_q   <= 1'b0;
			cap_q       <= ebs_pkg::DATA_RST;
			rsp_valid_q <= 1'b0;
			bus_q       <= ebs_pkg::BUS_IDLE;
		end else begin
			st_q        <= st_d;
			len_q       <= len_d;
			cmd_q       <= cmd_d;
			mode_q      <= mode_d;
			started_q   <= started_d;
			cap_q       <= cap_d;
			rsp_valid_q <= rsp_valid_d;
			bus_q       <= bus_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	t2_after_t1_a: assert property ((st_q == ebs_pkg::ST_T2) && ($past(st_q) != ebs_pkg::ST_T2) |-> $past(st_q) == ebs_pkg::ST_T1) else $error("T2 not entered from T1"); // [RULE_01]
	t1_addr_a: assert property (st_q == ebs_pkg::ST_T1 |-> bus_q.data_oe && !bus_q.chip_select_n && (bus_q.data_out == cmd_q.addr[ebs_pkg::DATA_W-1:0])) else $error("T1 address missing"); // [RULE_02]
	ale_start_a: assert property ((st_q == ebs_pkg::ST_T1) && ($past(st_q) != ebs_pkg::ST_T1) |-> bus_q.ale) else $error("Latch pulse not high at T1 start"); // [RULE_03]
	ale_end_a: assert property ((st_q == ebs_pkg::ST_T1) && tm_last |-> !bus_q.ale) else $error("Latch pulse still high at T1 end"); // [RULE_03]
	t2_read_a: assert property ((st_q == ebs_pkg::ST_T2) && !cmd_q.write |-> !bus_q.data_oe && !bus_q.read_strobe_n && (bus_q.memory_request_n == cmd_q.io) && (bus_q.io_request_n == !cmd_q.io)) else $error("T2 read signals wrong"); // [RULE_04]
	t3_hold_a: assert property ((st_q == ebs_pkg::ST_T3) && ($past(st_q) == ebs_pkg::ST_T3) |-> $stable(bus_q)) else $error("Bus changed in T3"); // [RULE_05]
	ready_stall_a: assert property ((st_q == ebs_pkg::ST_T3) && tm_last && !rdy_f_q |=> st_q == ebs_pkg::ST_TSTALL) else $error("No stall on ready low"); // [RULE_05]
	t4_read_a: assert property ((st_q == ebs_pkg::ST_T4) && ($past(st_q) != ebs_pkg::ST_T4) && !cmd_q.write |-> bus_q.read_strobe_n && (cap_q == $past(data_in))) else $error("T4 read capture wrong"); // [RULE_06]
	t2_write_a: assert property ((st_q == ebs_pkg::ST_T2) && cmd_q.write |-> bus_q.data_oe && (bus_q.data_out == cmd_q.wdata) && !bus_q.write_strobe_n) else $error("T2 write signals wrong"); // [RULE_07]
	t4_write_a: assert property ((st_q == ebs_pkg::ST_T4) && cmd_q.write |-> bus_q.write_strobe_n && bus_q.data_oe && (bus_q.data_out == cmd_q.wdata) && (bus_q.addr_out == cmd_q.addr)) else $error("T4 write hold wrong"); // [RULE_08]
	s5_order_a: assert property ((st_q == ebs_pkg::ST_S5) && ($past(st_q) != ebs_pkg::ST_S5) |-> $past(st_q) inside {ebs_pkg::ST_S4, ebs_pkg::ST_SSTALL}) else $error("S5 out of order"); // [RULE_09]
	s0_dir_a: assert property ((st_q == ebs_pkg::ST_S0) && !cmd_q.write |-> bus_q.rw_dir) else $error("Direction not read in S0"); // [RULE_10]
	s1_addr_a: assert property (st_q == ebs_pkg::ST_S1 |-> bus_q.addr_out == cmd_q.addr) else $error("S1 address invalid"); // [RULE_11]
	s2_strobe_a: assert property ((st_q == ebs_pkg::ST_S2) && !cmd_q.write |-> !bus_q.address_strobe_n && !bus_q.data_strobe_n) else $error("S2 strobes not asserted"); // [RULE_12]
	s_hold_a: assert property ((st_q inside {ebs_pkg::ST_S3, ebs_pkg::ST_S5}) && !cmd_q.write && ($past(st_q) != ebs_pkg::ST_IDLE) |-> $stable(bus_q)) else $error("Bus changed in S3 or S5"); // [RULE_13]
	ack_stall_a: assert property ((st_q == ebs_pkg::ST_S4) && tm_last && ack_f_q |=> st_q == ebs_pkg::ST_SSTALL) else $error("No stall without acknowledge"); // [RULE_14]
	stall_len_a: assert property ((st_q == ebs_pkg::ST_SSTALL) && (st_d != ebs_pkg::ST_SSTALL) |-> tm_cnt == (len_q - ebs_pkg::CNT_ONE)) else $error("Stall shorter than a state"); // [RULE_15]
	len_range_a: assert property (st_q != ebs_pkg::ST_IDLE |-> (len_q >= ebs_pkg::LEN_MIN) && (len_q <= ebs_pkg::LEN_MAX)) else $error("State length out of range"); // [RULE_16]
	low_addr_a: assert property (st_q == ebs_pkg::ST_T1 |-> bus_q.addr_out[ebs_pkg::DATA_W-1:0] == bus_q.data_out) else $error("Low address byte missing"); // [RULE_17]
	s7_capture_a: assert property ((st_q == ebs_pkg::ST_S7) && ($past(st_q) == ebs_pkg::ST_S6) && !cmd_q.write |-> bus_q.address_strobe_n && bus_q.data_strobe_n && (cap_q == $past(data_in))) else $error("S7 capture wrong"); // [RULE_18]
	switch_gap_a: assert property (st_q == ebs_pkg::ST_SWITCH |=> st_q inside {ebs_pkg::ST_T1, ebs_pkg::ST_S0}) else $error("Switch gap not one clock"); // [RULE_19]
	idle_levels_a: assert property (st_q == ebs_pkg::ST_IDLE && $past(st_q) == ebs_pkg::ST_IDLE |-> bus_q.read_strobe_n && bus_q.write_strobe_n && bus_q.address_strobe_n && bus_q.data_strobe_n) else $error("Strobe active while idle"); // [RULE_20]

	mux_stall_c: cover property (st_q == ebs_pkg::ST_TSTALL ##1 st_q == ebs_pkg::ST_T4);
	strobe_stall_c: cover property (st_q == ebs_pkg::ST_SSTALL ##1 st_q == ebs_pkg::ST_S5);
	mode_switch_c: cover property (st_q == ebs_pkg::ST_SWITCH);
	mux_write_c: cover property (rsp_valid_q && cmd_q.write && (cmd_q.mode == ebs_pkg::EBS_MODE_MUX4));

endmodule

// *** ebs_pkg.sv ***
package ebs_pkg;

	localparam int ADDR_W = 24;
	localparam int DATA_W = 8;
	localparam int LEN_W  = 4;

	// Bus state length limits, in system clocks
	localparam logic [LEN_W-1:0] LEN_MIN  = 4'h2;
	localparam logic [LEN_W-1:0] LEN_MAX  = 4'hf;
	localparam logic [LEN_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [LEN_W-1:0] CNT_ONE  = 4'h1;

	// Synchroniser reset levels
	localparam logic READY_RST = 1'b1;
	localparam logic ACK_N_RST = 1'b1;

	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;

	typedef enum logic {
		EBS_MODE_MUX4,
		EBS_MODE_STROBE8
	} ebs_mode_t;

	typedef enum logic [4:0] {
		ST_IDLE,
		ST_SWITCH,
		ST_T1,
		ST_T2,
		ST_T3,
		ST_TSTALL,
		ST_T4,
		ST_S0,
		ST_S1,
		ST_S2,
		ST_S3,
		ST_S4,
		ST_SSTALL,
		ST_S5,
		ST_S6,
		ST_S7
	} ebs_state_t;

	typedef struct packed {
		logic              write;
		logic              io;
		ebs_mode_t         mode;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ebs_req_t;

	typedef struct packed {
		logic              chip_select_n;
		logic              ale;
		logic              read_strobe_n;
		logic              write_strobe_n;
		logic              memory_request_n;
		logic              io_request_n;
		logic              rw_dir;
		logic              address_strobe_n;
		logic              data_strobe_n;
		logic              data_oe;
		logic [DATA_W-1:0] data_out;
		logic [ADDR_W-1:0] addr_out;
	} ebs_bus_t;

	localparam ebs_bus_t BUS_IDLE = '{
		chip_select_n:    1'b1,
		ale:              1'b0,
		read_strobe_n:    1'b1,
		write_strobe_n:   1'b1,
		memory_request_n: 1'b1,
		io_request_n:     1'b1,
		rw_dir:           1'b1,
		address_strobe_n: 1'b1,
		data_strobe_n:    1'b1,
		data_oe:          1'b0,
		data_out:         DATA_RST,
		addr_out:         ADDR_RST
	};

endpackage

// *** ebs_state_timer.sv ***
`timescale 1ns/100ps
module ebs_state_timer (
	input  wire logic                     sys_clk,
	input  wire logic                     rst_n,
	input  wire logic                     clear,
	input  wire logic [ebs_pkg::LEN_W-1:0] len,
	output logic      [ebs_pkg::LEN_W-1:0] cnt_q,
	output logic      [ebs_pkg::LEN_W-1:0] cnt_d,
	output logic                          last
);

	////////////////////////////////////////////////////////////////////////
	// Clock count within one bus state
	always_comb begin
		last = (cnt_q == (len - ebs_pkg::CNT_ONE));
		if (clear || last) begin
			cnt_d = ebs_pkg::CNT_ZERO;
		end else begin
			cnt_d = cnt_q + ebs_pkg::CNT_ONE;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= ebs_pkg::CNT_ZERO;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule

// *** ebs_periph_model.sv ***
`timescale 1ns/100ps
module ebs_periph_model (
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire ebs_pkg::ebs_bus_t bus,
	input  wire logic [7:0]        rd_val,
	input  wire logic [7:0]        hold,
	output logic      [7:0]        data_in,
	output logic                   ready_in,
	output logic                   transfer_ack_n
);
	logic       cs_q;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic       drive;

	// Read data only while a read strobe or the acknowledge is out
	assign drive = (!bus.read_strobe_n && !bus.data_oe) || (!transfer_ack_n && bus.rw_dir);

	// Hold count loads on the edge that sees chip select fall
	always_comb begin
		if (cs_q && !bus.chip_select_n) begin
			cnt_d = hold;
		end else if (cnt_q != 8'h00) begin
			cnt_d = cnt_q - 8'h01;
		end else begin
			cnt_d = cnt_q;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_q           <= 1'b1;
			cnt_q          <= 8'h00;
			ready_in       <= 1'b1;
			transfer_ack_n <= 1'b1;
			data_in        <= 8'h00;
		end else begin
			cs_q           <= bus.chip_select_n;
			cnt_q          <= cnt_d;
			ready_in       <= bus.chip_select_n || (cnt_d == 8'h00);
			transfer_ack_n <= !(!bus.address_strobe_n && cnt_d == 8'h00);
			data_in        <= drive ? rd_val : ~data_in;
		end
	end
endmodule

// *** ebs_sequencer_test.sv ***
`timescale 1ns/100ps
module ebs_sequencer_test;
	typedef struct packed {
		logic              write;
		logic              io;
		ebs_pkg::ebs_mode_t mode;
		logic [23:0]       addr;
		logic [7:0]        wdata;
		logic [3:0]        len;
		logic              slow;
		logic [7:0]        rd;
	} ebs_row_t;
	localparam ebs_pkg::ebs_mode_t M4 = ebs_pkg::EBS_MODE_MUX4;
	localparam ebs_pkg::ebs_mode_t S8 = ebs_pkg::EBS_MODE_STROBE8;

	logic               sys_clk;
	logic               rst_n;
	logic               req_valid;
	logic               req_ready;
	ebs_pkg::ebs_req_t  req;
	logic [3:0]         state_len;
	logic               rsp_valid;
	logic [7:0]         rsp_rdata;
	ebs_pkg::ebs_bus_t  bus;
	logic [7:0]         data_in;
	logic               ready_in;
	logic               transfer_ack_n;
	logic [7:0]         rd_val;
	logic [7:0]         hold;
	int                 failures;
	int                 cmp_count;
	int                 cyc;
	logic               prev_ok;
	ebs_pkg::ebs_mode_t prev_mode;
	ebs_row_t           rows [10];

	ebs_sequencer u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
		.req_ready(req_ready), .req(req), .state_len(state_len), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .bus(bus), .data_in(data_in), .ready_in(ready_in),
		.transfer_ack_n(transfer_ack_n));
	ebs_periph_model u_periph (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .rd_val(rd_val),
		.hold(hold), .data_in(data_in), .ready_in(ready_in), .transfer_ack_n(transfer_ack_n));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		$display("Checks %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// One whole bus cycle, counted cycle by cycle from the take edge
	task automatic run_row(input ebs_row_t r);
		int n, l, sw, s, tot, k, rs, ws, wd, al, af, as_c, ds_c;
		l = (r.len < 4'h2) ? 2 : int'(r.len);
		sw = (prev_ok && prev_mode != r.mode) ? 1 : 0;
		s = (r.mode == M4) ? 4 : 8;
		rd_val = r.rd;
		hold = r.slow ? 8'(5 * l + 2) : 8'h00;
		req = '{write: r.write, io: r.io, mode: r.mode, addr: r.addr, wdata: r.wdata};
		state_len = r.len;
		req_valid = 1'b1;
		while (req_ready !== 1'b1) begin
			@(posedge sys_clk);
			#1;
		end
		@(posedge sys_clk);
		#1;
		req_valid = 1'b0;
		{n, rs, ws, wd, al, as_c, ds_c} = '0;
		af = -1;
		while (rsp_valid !== 1'b1 && n < 400) begin
			if (bus.ale === 1'b1) begin
				al++;
				if (af < 0) af = n;
				chk({bus.chip_select_n, bus.data_oe, bus.data_out}, {2'b01, r.addr[7:0]});
			end
			if (bus.chip_select_n === 1'b0) chk(bus.addr_out[7:0], r.addr[7:0]);
			if (bus.read_strobe_n === 1'b0) begin
				rs++;
				chk({bus.data_oe, bus.io_request_n, bus.memory_request_n}, {1'b0, !r.io, r.io});
			end
			if (bus.write_strobe_n === 1'b0) begin
				ws++;
				chk({bus.io_request_n, bus.memory_request_n}, {!r.io, r.io});
			end
			if (bus.chip_select_n === 1'b0 && bus.data_oe === 1'b1 && bus.data_out === r.wdata) wd++;
			if (bus.address_strobe_n === 1'b0) begin
				as_c++;
				chk({bus.addr_out, bus.rw_dir}, {r.addr, !r.write});
			end
			if (bus.data_strobe_n === 1'b0) ds_c++;
			if (n == sw && r.mode == S8 && !r.write) chk({bus.chip_select_n, bus.rw_dir}, 2'b01);
			@(posedge sys_clk);
			#1;
			n++;
		end
		tot = n - sw;
		k = tot / l - s;
		chk(tot % l, 0);
		if (!r.slow) chk(tot, s * l);
		else chk(k >= 1 && k <= 8, 1);
		if (r.mode == M4) begin
			chk({al, af}, {l / 2, sw});
			if (r.write) chk({ws, wd}, {(2 + k) * l, (3 + k) * l});
			else chk({rs, 24'h0, rsp_rdata}, {(2 + k) * l, 24'h0, r.rd});
		end else begin
			chk(as_c, (5 + k) * l);
			if (r.write) chk({ds_c, wd}, {(3 + k) * l, (5 + k) * l});
			else chk({ds_c, 24'h0, rsp_rdata}, {(5 + k) * l, 24'h0, r.rd});
		end
		prev_ok = 1'b1;
		prev_mode = r.mode;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			final_report();
		end
	end

	initial begin
		rows = '{
			'{1'b0, 1'b0, M4, 24'h12_3456, 8'ha1, 4'h2, 1'b0, 8'h3c},
			'{1'b1, 1'b1, M4, 24'h00_80f0, 8'h0f, 4'h2, 1'b1, 8'h00},
			'{1'b0, 1'b1, M4, 24'hab_cd11, 8'h22, 4'h3, 1'b1, 8'hc5},
			'{1'b0, 1'b0, S8, 24'hfe_dc33, 8'h44, 4'h2, 1'b0, 8'h96},
			'{1'b0, 1'b0, S8, 24'h01_0255, 8'h66, 4'h2, 1'b1, 8'h69},
			'{1'b1, 1'b0, S8, 24'h5a_a577, 8'h88, 4'h3, 1'b0, 8'h00},
			'{1'b1, 1'b0, M4, 24'hff_ff99, 8'hbb, 4'hf, 1'b0, 8'h00},
			'{1'b0, 1'b0, M4, 24'h7e_e7cc, 8'hdd, 4'h0, 1'b1, 8'hf0},
			'{1'b1, 1'b0, S8, 24'h33_33ee, 8'h12, 4'h1, 1'b1, 8'h00},
			'{1'b0, 1'b0, M4, 24'h80_0001, 8'h34, 4'hf, 1'b1, 8'h81}};
		{failures, cmp_count, cyc} = '0;
		prev_ok = 1'b0;
		prev_mode = M4;
		rst_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		state_len = 4'h2;
		rd_val = 8'h00;
		hold = 8'h00;
		repeat (3) @(posedge sys_clk);
		#1;
		chk({bus, rsp_valid, req_ready}, {ebs_pkg::BUS_IDLE, 2'b01});
		rst_n = 1'b1;
		foreach (rows[i]) run_row(rows[i]);
		// Reset in the middle of a write cycle
		req = '{write: 1'b1, io: 1'b0, mode: M4, addr: 24'h44_5566, wdata: 8'h77};
		req_valid = 1'b1;
		repeat (6) @(posedge sys_clk);
		#1;
		req_valid = 1'b0;
		rst_n = 1'b0;
		#1;
		chk({bus, rsp_valid, req_ready, rsp_rdata}, {ebs_pkg::BUS_IDLE, 10'h100});
		repeat (2) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		prev_ok = 1'b0;
		run_row(rows[0]);
		final_report();
	end
endmodule
